// >>> hdl/ebm_top.sv
module ebm_top
  import ebm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire ebm_port_type i_port_a,
  input wire ebm_port_type i_port_b,
  input wire logic i_port_a_output_reset,
  input wire logic i_port_b_output_reset,
  input wire logic i_global_reset_low,
  output logic [EBM_DW-1:0] o_port_a_dout,
  output logic [EBM_DW-1:0] o_port_b_dout
);

  ebm_state_type state_r;
  ebm_state_type state_nxt;

  logic init_we;
  logic addr_ok;
  logic coll_evt;
  logic [1:0] we_ok;
  logic [1:0] rd_ok;
  logic [1:0] ini;
  logic [1:0] we;
  logic [1:0] rd;
  logic [1:0] ld;
  logic [1:0] lat_ld;
  logic [1:0] rst_req;
  logic [1:0] aclr;
  logic [1:0] sclr;
  logic [1:0] wt;
  logic [1:0] oreg;
  logic [1:0] async_sel;
  logic [1:0] prst;
  logic [2:0] wid [2];
  logic [4:0] sh [2];
  logic [EBM_DW-1:0] wm [2];
  logic [EBM_DW-1:0] val [2];
  logic [EBM_DW-1:0] lat_d [2];
  logic [EBM_DW-1:0] q [2];
  logic [EBM_DW-1:0] rdw [2];
  logic arr_we [2];
  logic [EBM_IW-1:0] arr_idx [2];
  logic [EBM_DW-1:0] arr_msk [2];
  logic [EBM_DW-1:0] arr_dat [2];

  // Per-port configuration view
  assign wid[0] = state_r.cfg.wid_a;
  assign wid[1] = state_r.cfg.wid_b;
  assign wt = {state_r.cfg.wt_b, state_r.cfg.wt_a};
  assign oreg = {state_r.cfg.oreg_b, state_r.cfg.oreg_a};
  assign async_sel = {state_r.cfg.async_b, state_r.cfg.async_a};
  assign prst = {i_port_b_output_reset, i_port_a_output_reset};

  // Arrangement decides which port may write or read
  always_comb begin
    we_ok[0] = state_r.cfg.mode != EBM_MODE_ROM;
    we_ok[1] = state_r.cfg.mode == EBM_MODE_TDP;
    rd_ok[0] = state_r.cfg.mode != EBM_MODE_PDP;
    rd_ok[1] = state_r.cfg.mode != EBM_MODE_SP;
  end

  // Init write from the bus borrows port A for one cycle
  assign init_we = state_r.ph_wr && (state_r.ph_ofs == EBM_OFS_INIT_DATA);
  assign ini = {1'b0, init_we};
  assign coll_evt = we[0] && we[1] && (arr_idx[0] == arr_idx[1]);

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      assign sh[p] = ebm_shift(wid[p], state_r.prt[p].addr);
      assign wm[p] = ebm_wmask(wid[p]);
      assign we[p] = state_r.prt[p].en && state_r.prt[p].we &&
                     we_ok[p] && !ini[p];
      assign rd[p] = state_r.prt[p].en && !(state_r.prt[p].we &&
                     we_ok[p]) && rd_ok[p] && !ini[p];
      assign arr_we[p] = we[p] || ini[p];
      assign arr_idx[p] = ini[p] ? state_r.init_idx :
                          ebm_index(wid[p], state_r.prt[p].addr);
      assign arr_msk[p] = ini[p] ? EBM_FULL_MASK : (wm[p] << sh[p]);
      assign arr_dat[p] = ini[p] ? i_hwdata[EBM_DW-1:0] :
                          ((state_r.prt[p].din & wm[p]) << sh[p]);
      // Reads load the latch; writes only in write-through
      assign ld[p] = rd[p] || (we[p] && wt[p]);
      assign val[p] = rd[p] ? ((rdw[p] >> sh[p]) & wm[p]) :
                      (state_r.prt[p].din & wm[p]);
      assign lat_ld[p] = oreg[p] ? state_r.vld[p] : ld[p];
      assign lat_d[p] = oreg[p] ? state_r.pipe[p] : val[p];
      assign rst_req[p] = prst[p] || !i_global_reset_low;
      assign aclr[p] = async_sel[p] && rst_req[p];
      assign sclr[p] = !async_sel[p] && rst_req[p];
      ebm_out_latch u_latch (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_aclr(aclr[p]),
        .i_sclr(sclr[p]),
        .i_load(lat_ld[p]),
        .i_d(lat_d[p]),
        .o_q(q[p])
      );
    end
  endgenerate

  ebm_array u_array (
    .i_clk(i_clk),
    .i_we_a(arr_we[0]),
    .i_idx_a(arr_idx[0]),
    .i_msk_a(arr_msk[0]),
    .i_dat_a(arr_dat[0]),
    .i_we_b(arr_we[1]),
    .i_idx_b(arr_idx[1]),
    .i_msk_b(arr_msk[1]),
    .i_dat_b(arr_dat[1]),
    .o_rd_a(rdw[0]),
    .o_rd_b(rdw[1])
  );

  assign addr_ok = i_hsel && i_htrans[1] && i_hready;

  always_comb begin
    state_nxt = state_r;
    state_nxt.prt[0] = i_port_a;
    state_nxt.prt[1] = i_port_b;
    state_nxt.vld = ld;
    state_nxt.pipe[0] = val[0];
    state_nxt.pipe[1] = val[1];
    // Bus data phase writes
    if (state_r.ph_wr) begin
      case (state_r.ph_ofs)
        EBM_OFS_CFG: begin
          state_nxt.cfg = ebm_cfg_type'(i_hwdata);
          state_nxt.cfg.rsvd = '0;
        end
        EBM_OFS_INIT_ADDR: begin
          state_nxt.init_idx = i_hwdata[EBM_IW-1:0];
        end
        EBM_OFS_INIT_DATA: begin
          state_nxt.init_dat = i_hwdata[EBM_DW-1:0];
          state_nxt.init_idx = state_r.init_idx + 10'h001;
        end
        EBM_OFS_STATUS: begin
          if (i_hwdata[0]) begin
            state_nxt.coll = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    if (coll_evt) begin
      state_nxt.coll = 1'b1;
    end
    // Address phase; reads see this cycle's writes
    state_nxt.ph_wr = addr_ok && i_hwrite;
    state_nxt.ph_ofs = i_haddr[7:0];
    state_nxt.hrdata = '0;
    if (addr_ok && !i_hwrite) begin
      case (i_haddr[7:0])
        EBM_OFS_CFG: state_nxt.hrdata = state_nxt.cfg;
        EBM_OFS_INIT_ADDR: state_nxt.hrdata = {22'h0, state_nxt.init_idx};
        EBM_OFS_INIT_DATA: state_nxt.hrdata = {14'h0, state_nxt.init_dat};
        EBM_OFS_STATUS: state_nxt.hrdata = {31'h0, state_nxt.coll};
        default: state_nxt.hrdata = '0;
      endcase
    end
    state_nxt.hreadyout = 1'b1;
    state_nxt.hresp = EBM_HRESP_OKAY;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= '0;
      state_r.cfg <= EBM_CFG_RST;
      state_r.hreadyout <= 1'b1;
      state_r.hresp <= EBM_HRESP_OKAY;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_hrdata = state_r.hrdata;
  assign o_hreadyout = state_r.hreadyout;
  assign o_hresp = state_r.hresp;
  assign o_port_a_dout = q[0];
  assign o_port_b_dout = q[1];

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_input_reg: assert property (
    (i_port_b.en && i_port_b.we && !$past(i_rst) &&
     state_r.cfg.mode == EBM_MODE_TDP && state_nxt.cfg == state_r.cfg)
    |=> (arr_we[1] && arr_dat[1] == (($past(i_port_b.din) & wm[1])
         << sh[1])))
    else $error("port B write not registered before array");

  a_normal_hold: assert property (
    (we[0] && !wt[0] && !oreg[0] && !rst_req[0])
    |=> ($stable(o_port_a_dout) || rst_req[0]))
    else $error("normal write changed port A output");

  a_hold_b: assert property (
    (we[1] && !wt[1] && !oreg[1] && !rst_req[1])
    |=> ($stable(o_port_b_dout) || rst_req[1]))
    else $error("normal write changed port B output");

  a_thru_copy: assert property (
    (we[0] && wt[0] && !oreg[0] && !rst_req[0])
    |=> (o_port_a_dout == $past(val[0]) || rst_req[0]))
    else $error("write-through data missing on port A");

  a_thru_width: assert property (
    (we[1] && wt[1] && !oreg[1] && !rst_req[1])
    |=> ((o_port_b_dout & ~$past(wm[1])) == '0 || rst_req[1]))
    else $error("write-through data wider than port B width");

  a_read_path: assert property (
    (rd[0] && !oreg[0] && !rst_req[0])
    |=> (o_port_a_dout == $past(val[0]) || rst_req[0]))
    else $error("port A read data not shown after one cycle");

  a_oreg_delay: assert property (
    (rd[1] && oreg[1] && !rst_req[1]) ##1 (oreg[1] && !rst_req[1])
    |=> (o_port_b_dout == $past(val[1], 2) || rst_req[1]))
    else $error("port B output register latency wrong");

  a_sync_clear: assert property (
    (rst_req[0] && !async_sel[0]) |=> (o_port_a_dout == '0))
    else $error("port A synchronous clear failed");

  a_async_clear: assert property (
    aclr[1] |-> (o_port_b_dout == '0))
    else $error("port B asynchronous clear failed");

  a_port_isolation: assert property (
    (i_port_a_output_reset && !rst_req[1] && !lat_ld[1])
    |=> ($stable(o_port_b_dout) || rst_req[1]))
    else $error("port A reset disturbed port B");

  a_global_both: assert property (
    (!i_global_reset_low)
    |=> (o_port_a_dout == '0 && o_port_b_dout == '0))
    else $error("global reset left an output set");

  a_rom_nowrite: assert property (
    (state_r.cfg.mode == EBM_MODE_ROM && !init_we)
    |-> (!arr_we[0] && !arr_we[1]))
    else $error("array written in read-only mode");

  a_single_quiet: assert property (
    (state_r.cfg.mode == EBM_MODE_SP) |-> (!arr_we[1] && !rd[1]))
    else $error("port B active in single port mode");

  a_coll_flag: assert property (
    coll_evt |=> state_r.coll)
    else $error("collision not flagged");

  a_thru_copy_b: assert property (
    (we[1] && wt[1] && !oreg[1] && !rst_req[1])
    |=> (o_port_b_dout == $past(val[1]) || rst_req[1]))
    else $error("write-through data missing on port B");

  a_oreg_a_delay: assert property (
    (rd[0] && oreg[0] && !rst_req[0]) ##1 (oreg[0] && !rst_req[0])
    |=> (o_port_a_dout == $past(val[0], 2) || rst_req[0]))
    else $error("port A output register latency wrong");

  a_b_isolation: assert property (
    (i_port_b_output_reset && !rst_req[0] && !lat_ld[0])
    |=> ($stable(o_port_a_dout) || rst_req[0]))
    else $error("port B reset disturbed port A");

  c_thru_a: cover property (we[0] && wt[0]);
  c_oreg_b: cover property (rd[1] && oreg[1] ##2 lat_ld[1]);
  c_pdp: cover property (state_r.cfg.mode == EBM_MODE_PDP && we[0] && rd[1]);
  c_async: cover property (aclr[0]);
  c_coll: cover property (coll_evt);

endmodule

// >>> hdl/ebm_pkg.sv
package ebm_pkg;

  // Storage: 18 Kbit as 1024 words of 18 bits
  localparam int EBM_BITS = 18432;
  localparam int EBM_DW = 18;
  localparam int EBM_DEPTH = EBM_BITS / EBM_DW;
  localparam int EBM_IW = 10;
  localparam int EBM_AW = 14;

  // Port width codes
  localparam logic [2:0] EBM_W1 = 3'h0;
  localparam logic [2:0] EBM_W2 = 3'h1;
  localparam logic [2:0] EBM_W4 = 3'h2;
  localparam logic [2:0] EBM_W9 = 3'h3;
  localparam logic [2:0] EBM_W18 = 3'h4;

  // Port arrangements
  localparam logic [1:0] EBM_MODE_SP = 2'h0;
  localparam logic [1:0] EBM_MODE_TDP = 2'h1;
  localparam logic [1:0] EBM_MODE_PDP = 2'h2;
  localparam logic [1:0] EBM_MODE_ROM = 2'h3;

  // Register offsets
  localparam logic [7:0] EBM_OFS_CFG = 8'h00;
  localparam logic [7:0] EBM_OFS_INIT_ADDR = 8'h04;
  localparam logic [7:0] EBM_OFS_INIT_DATA = 8'h08;
  localparam logic [7:0] EBM_OFS_STATUS = 8'h0C;

  localparam logic EBM_HRESP_OKAY = 1'b0;
  localparam logic [EBM_DW-1:0] EBM_FULL_MASK = 18'h3FFFF;

  typedef struct packed {
    logic [17:0] rsvd;
    logic async_b;
    logic async_a;
    logic wt_b;
    logic wt_a;
    logic oreg_b;
    logic oreg_a;
    logic [2:0] wid_b;
    logic [2:0] wid_a;
    logic [1:0] mode;
  } ebm_cfg_type;

  // Single port, 18 bits wide on both ports
  localparam ebm_cfg_type EBM_CFG_RST = 32'h0000_0090;

  typedef struct packed {
    logic en;
    logic we;
    logic [EBM_AW-1:0] addr;
    logic [EBM_DW-1:0] din;
  } ebm_port_type;

  typedef struct packed {
    ebm_cfg_type cfg;
    logic [EBM_IW-1:0] init_idx;
    logic [EBM_DW-1:0] init_dat;
    logic coll;
    logic ph_wr;
    logic [7:0] ph_ofs;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    ebm_port_type [1:0] prt;
    logic [1:0] vld;
    logic [1:0][EBM_DW-1:0] pipe;
  } ebm_state_type;

  function automatic logic [EBM_IW-1:0] ebm_index(logic [2:0] w,
                                                  logic [EBM_AW-1:0] a);
    case (w)
      EBM_W1: ebm_index = a[13:4];
      EBM_W2: ebm_index = a[12:3];
      EBM_W4: ebm_index = a[11:2];
      EBM_W9: ebm_index = a[10:1];
      default: ebm_index = a[9:0];
    endcase
  endfunction

  function automatic logic [4:0] ebm_shift(logic [2:0] w,
                                           logic [EBM_AW-1:0] a);
    case (w)
      EBM_W1: ebm_shift = {1'b0, a[3:0]};
      EBM_W2: ebm_shift = {1'b0, a[2:0], 1'b0};
      EBM_W4: ebm_shift = {1'b0, a[1:0], 2'b00};
      EBM_W9: ebm_shift = a[0] ? 5'h09 : 5'h00;
      default: ebm_shift = 5'h00;
    endcase
  endfunction

  function automatic logic [EBM_DW-1:0] ebm_wmask(logic [2:0] w);
    case (w)
      EBM_W1: ebm_wmask = 18'h00001;
      EBM_W2: ebm_wmask = 18'h00003;
      EBM_W4: ebm_wmask = 18'h0000F;
      EBM_W9: ebm_wmask = 18'h001FF;
      default: ebm_wmask = EBM_FULL_MASK;
    endcase
  endfunction

endpackage

// >>> hdl/ebm_array.sv
module ebm_array
  import ebm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_we_a,
  input wire logic [EBM_IW-1:0] i_idx_a,
  input wire logic [EBM_DW-1:0] i_msk_a,
  input wire logic [EBM_DW-1:0] i_dat_a,
  input wire logic i_we_b,
  input wire logic [EBM_IW-1:0] i_idx_b,
  input wire logic [EBM_DW-1:0] i_msk_b,
  input wire logic [EBM_DW-1:0] i_dat_b,
  output logic [EBM_DW-1:0] o_rd_a,
  output logic [EBM_DW-1:0] o_rd_b
);

  logic [EBM_DW-1:0] mem_r [EBM_DEPTH];
  logic [EBM_DW-1:0] new_a;
  logic [EBM_DW-1:0] new_b;
  logic same;

  // Lanes of one word written by both ports merge; B wins on overlap
  always_comb begin
    same = i_we_a && i_we_b && (i_idx_a == i_idx_b);
    new_a = (mem_r[i_idx_a] & ~i_msk_a) | (i_dat_a & i_msk_a);
    new_b = ((same ? new_a : mem_r[i_idx_b]) & ~i_msk_b) |
            (i_dat_b & i_msk_b);
  end

  always_ff @(posedge i_clk) begin
    if (i_we_a && !same) begin
      mem_r[i_idx_a] <= new_a;
    end
    if (i_we_b) begin
      mem_r[i_idx_b] <= new_b;
    end
  end

  assign o_rd_a = mem_r[i_idx_a];
  assign o_rd_b = mem_r[i_idx_b];

endmodule

// >>> hdl/ebm_out_latch.sv
module ebm_out_latch
  import ebm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_aclr,
  input wire logic i_sclr,
  input wire logic i_load,
  input wire logic [EBM_DW-1:0] i_d,
  output logic [EBM_DW-1:0] o_q
);

  logic [EBM_DW-1:0] q_r;
  logic [EBM_DW-1:0] q_nxt;

  // Holds last value unless loaded or cleared
  always_comb begin
    q_nxt = q_r;
    if (i_rst || i_sclr) begin
      q_nxt = '0;
    end else if (i_load) begin
      q_nxt = i_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_aclr) begin
    if (i_aclr) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r;

endmodule

// >>> dv/ebm_fabric.sv
module ebm_fabric
  import ebm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire ebm_port_type i_req_a,
  input wire ebm_port_type i_req_b,
  output ebm_port_type o_port_a,
  output ebm_port_type o_port_b
);
  // Registers each access; idle lines toggle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_port_a <= '0;
      o_port_b <= '0;
    end else begin
      o_port_a <= i_req_a.en ? i_req_a : {1'b0, ~o_port_a[32:0]};
      o_port_b <= i_req_b.en ? i_req_b : {1'b0, ~o_port_b[32:0]};
      if (i_req_a.en && i_req_a.we && i_req_b.en && i_req_b.we &&
          i_req_a.addr == i_req_b.addr) begin
        o_port_b.we <= 1'b0;
      end
    end
  end
endmodule

// >>> dv/tb.sv
module tb
  import ebm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, hsel, hwrite, hrdy, hresp, ra, rb, gn;
  logic [31:0] haddr, hwdata, hrdata, seed, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [17:0] da, db, d, u, v, mem [64];
  ebm_port_type qa, qb, pa, pb;
  int error_cnt, checked, oreg, idx;
  logic [13:0] a;

  ebm_fabric u_fab (.i_clk(clk), .i_rst(rst), .i_req_a(qa),
    .i_req_b(qb), .o_port_a(pa), .o_port_b(pb));
  ebm_top u_dut (.i_clk(clk), .i_rst(rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .i_port_a(pa), .i_port_b(pb), .i_port_a_output_reset(ra),
    .i_port_b_output_reset(rb), .i_global_reset_low(gn),
    .o_port_a_dout(da), .o_port_b_dout(db));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [17:0] msk(int w);
    case (w)
      0: return 18'h00001;
      1: return 18'h00003;
      2: return 18'h0000F;
      3: return 18'h001FF;
      default: return 18'h3FFFF;
    endcase
  endfunction

  function automatic int lg(int w);
    return (w > 3) ? 0 : 4 - w;
  endfunction

  function automatic int sh(int w, logic [13:0] x);
    if (w == 3) return x[0] ? 9 : 0;
    return (w > 3) ? 0 : int'(x[3:0] & 4'((1 << lg(w)) - 1)) << w;
  endfunction

  function automatic logic [31:0] cfg(logic [1:0] m, int w, bit o,
                                      bit t, bit s);
    return {18'h0, s, s, t, t, o, o, w[2:0], w[2:0], m};
  endfunction

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    @(negedge clk);
    while (hrdy !== 1'b1) begin
      n++;
      if (n > 20) begin
        error_cnt++;
        end_sim();
      end
      @(negedge clk);
    end
  endtask

  task automatic ahb(bit wr, logic [7:0] ad, logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
    chk("hresp", hresp, EBM_HRESP_OKAY);
    @(posedge clk);
    hsel <= 1'b0;
  endtask

  task automatic acc(bit b, bit we, logic [13:0] ad, logic [17:0] dv,
                     output logic [17:0] r);
    @(posedge clk);
    if (b) qb <= {1'b1, we, ad, dv};
    else qa <= {1'b1, we, ad, dv};
    @(posedge clk);
    qa <= '0;
    qb <= '0;
    repeat (2 + oreg) @(posedge clk);
    #1 r = b ? db : da;
  endtask

  initial begin
    seed = 32'h9C7F6350;
    {hsel, hwrite, ra, rb, haddr, hwdata, htrans, qa, qb} = '0;
    hsize = 3'h2;
    gn = 1'b1;
    rst = 1'b1;
    oreg = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    ahb(0, EBM_OFS_CFG, 0, rd);
    chk("cfg_rst", rd, 32'h00000090);
    ahb(0, 8'h10, 0, rd);
    chk("unmapped", rd, 32'h0);
    ahb(1, EBM_OFS_INIT_ADDR, 0, rd);
    for (int i = 0; i < 64; i++) begin
      mem[i] = rnd() & EBM_FULL_MASK;
      ahb(1, EBM_OFS_INIT_DATA, {14'h0, mem[i]}, rd);
    end
    ahb(0, EBM_OFS_INIT_ADDR, 0, rd);
    chk("init_idx", rd, 64);
    ahb(0, EBM_OFS_INIT_DATA, 0, rd);
    chk("init_dat", rd, mem[63]);
    for (int o = 0; o < 2; o++) begin
      ahb(1, EBM_OFS_CFG, cfg(EBM_MODE_TDP, 4, o[0], 0, 0), rd);
      oreg = o;
      for (int i = 0; i < 16; i++) begin
        acc(i[0], 0, 14'(i), 0, d);
        chk("rd18", d, mem[i]);
      end
    end
    oreg = 0;
    for (int w = 0; w < 5; w++) begin
      for (int t = 0; t < 2; t++) begin
        ahb(1, EBM_OFS_CFG, cfg(EBM_MODE_TDP, w, 0, t[0], 0), rd);
        idx = 32 + (rnd() % 32);
        a = 14'((idx << lg(w)) | (rnd() & ((1 << lg(w)) - 1)));
        acc(0, 0, a, 0, d);
        chk("old", d, (mem[idx] >> sh(w, a)) & msk(w));
        v = rnd() & msk(w);
        acc(0, 1, a, v, d);
        chk("wr_out", d, t ? v : (mem[idx] >> sh(w, a)) & msk(w));
        mem[idx] = (mem[idx] & ~(msk(w) << sh(w, a))) | (v << sh(w, a));
        acc(0, 0, a, 0, d);
        chk("rd_back", d, v);
      end
    end
    ahb(1, EBM_OFS_CFG, cfg(EBM_MODE_TDP, 4, 0, 0, 0), rd);
    v = rnd() & EBM_FULL_MASK;
    acc(1, 1, 14'h5, v, d);
    mem[5] = v;
    acc(0, 0, 14'h5, 0, d);
    chk("tdp_b_wr", d, v);
    ahb(1, EBM_OFS_CFG, cfg(EBM_MODE_PDP, 4, 0, 0, 0), rd);
    acc(1, 1, 14'h6, ~mem[6], d);
    acc(0, 1, 14'h7, v, d);
    mem[7] = v;
    acc(1, 0, 14'h6, 0, d);
    chk("pdp_b_nowr", d, mem[6]);
    acc(1, 0, 14'h7, 0, d);
    chk("pdp_a_wr", d, v);
    ahb(1, EBM_OFS_CFG, cfg(EBM_MODE_ROM, 4, 0, 0, 0), rd);
    acc(0, 1, 14'h8, ~mem[8], d);
    acc(0, 0, 14'h8, 0, d);
    chk("rom", d, mem[8]);
    // Port A x9 and port B x18 write one word together
    ahb(1, EBM_OFS_CFG, cfg(EBM_MODE_TDP, 4, 0, 1, 0) ^ 32'h0000001C, rd);
    ahb(0, EBM_OFS_CFG, 0, rd);
    chk("cfg_rd", rd, cfg(EBM_MODE_TDP, 4, 0, 1, 0) ^ 32'h0000001C);
    u = rnd() & EBM_FULL_MASK;
    v = rnd() & EBM_FULL_MASK;
    @(posedge clk);
    qa <= {1'b1, 1'b1, 14'h0014, u};
    qb <= {1'b1, 1'b1, 14'h000A, v};
    @(posedge clk);
    qa <= '0;
    qb <= '0;
    repeat (2) @(posedge clk);
    #1 chk("coll_a", da, u & 18'h001FF);
    chk("coll_b", db, v);
    mem[10] = v;
    ahb(0, EBM_OFS_STATUS, 0, rd);
    chk("coll_set", rd, 1);
    ahb(1, EBM_OFS_STATUS, 1, rd);
    ahb(0, EBM_OFS_STATUS, 0, rd);
    chk("coll_clr", rd, 0);
    acc(1, 0, 14'h000A, 0, d);
    chk("coll_word", d, mem[10]);
    // Single port: port B neither reads nor writes
    ahb(1, EBM_OFS_CFG, cfg(EBM_MODE_SP, 4, 0, 0, 0), rd);
    acc(1, 1, 14'h0004, ~mem[4], d);
    chk("sp_b_idle", d, mem[10]);
    acc(0, 0, 14'h0004, 0, d);
    chk("sp_b_nowr", d, mem[4]);
    ahb(1, EBM_OFS_CFG, cfg(EBM_MODE_TDP, 4, 0, 0, 0), rd);
    acc(0, 0, 14'h1, 0, d);
    acc(1, 0, 14'h2, 0, d);
    @(posedge clk);
    ra <= 1'b1;
    #1 chk("sync_wait", da, mem[1]);
    @(posedge clk);
    ra <= 1'b0;
    #1 chk("sync_clr", da, 0);
    chk("b_kept", db, mem[2]);
    acc(0, 0, 14'h1, 0, d);
    chk("arr_kept", d, mem[1]);
    ahb(1, EBM_OFS_CFG, cfg(EBM_MODE_TDP, 4, 0, 0, 1), rd);
    @(posedge clk);
    rb <= 1'b1;
    #1 chk("async_clr", db, 0);
    chk("a_kept", da, mem[1]);
    @(posedge clk);
    rb <= 1'b0;
    ahb(1, EBM_OFS_CFG, cfg(EBM_MODE_TDP, 4, 0, 0, 0), rd);
    acc(1, 0, 14'h2, 0, d);
    @(posedge clk);
    gn <= 1'b0;
    @(posedge clk);
    gn <= 1'b1;
    #1 chk("glob_a", da, 0);
    chk("glob_b", db, 0);
    end_sim();
  end
endmodule
